// ==== logic/psg_consts.vh ====
/*
 * register map, field positions and timing counts for the power save and
 * clock gating block.
 * assumes inclusion by bare name from the design file.
 */
`ifndef PSG_CONSTS_VH
`define PSG_CONSTS_VH

// ************************************************************
// register byte addresses (32-bit wishbone words)
// ************************************************************
`define PSG_ADDR_DISABLE1 8'h00
`define PSG_ADDR_CLOCK_DIVIDER_REGISTER 8'h04
`define PSG_ADDR_CONTROL 8'h08
`define PSG_ADDR_STATUS 8'h0c

// ************************************************************
// field positions and masks
// ************************************************************
`define PSG_DIS1_MASK 16'hf8ff
`define PSG_DIS1_RESET 16'h0000
`define PSG_DIV_ROI_BIT 15
`define PSG_DIV_RATIO_HI 14
`define PSG_DIV_RATIO_LO 12
`define PSG_DIV_CPU_SLOWDOWN_ENABLE_BIT 11
`define PSG_DIV_MASK 16'hf800
`define PSG_DIV_RESET 16'h0000
`define PSG_CTL_WDT_EN_BIT 0
`define PSG_CTL_CLOCK_FAILURE_MONITOR_EN_BIT 1
`define PSG_CTL_RESET 16'h0000
`define PSG_ADC1_BIT 0

// ************************************************************
// power save operand codes and timing
// ************************************************************
`define PSG_OP_SLEEP 1'b0
`define PSG_OP_IDLE 1'b1
`define PSG_CLK_NS 20
`define PSG_INSTR_NS 40
`define PSG_INSTR_CYC ((`PSG_INSTR_NS + `PSG_CLK_NS - 1) / `PSG_CLK_NS)
`define PSG_RESUME_CYC 3

`endif

// ==== logic/psg_power_save.v ====
/*
 * power save and clock gating block: sleep and idle state machine, doze
 * divider for the cpu clock enable, and peripheral disable register.
 * assumes a wishbone classic master on the system clock; wake inputs and
 * peripheral control come from the same clock domain except the
 * asynchronous wake lines, which are synchronised here.
 */
// Implementation choices: the Wishbone interface to the registers and the register addresses.
// Notes on behaviour
// - sleep stops the system clock and halts execution.
// - idle stops the cpu; enabled peripherals keep their clock.
// - sleep entry turns off the system clock source oscillator.
// - the clock failure monitor is held off during sleep.
// - in sleep the low power rc runs while the watchdog is enabled.
// - in idle the low power rc runs if watchdog or failure monitor enabled.
// - watchdog count is cleared before entering sleep.
// - watchdog count is cleared on idle entry.
// - sleep disables all peripherals needing the system clock.
// - wake on enabled interrupt, any reset, or watchdog time-out.
// - sleep wake restarts on the clock source used before sleep.
// - idle wake reapplies cpu clock; execution resumes 2-4 cycles later.
// - interrupt during the instruction is deferred, then wakes at once.
// - doze slows only the cpu clock; peripherals keep full clock.
// - doze active only while slowdown enable bit 11 is set.
// - bits 14:12 pick ratio 1:1 to 1:128, default 1:1.
// - restore-on-interrupt bit 15 returns cpu to full speed on interrupt.
// - disable bit stops clocks; module registers ignore writes, read invalid.
// - enabled only if present and bit clear; bits reset to zero.
// - disable bit change takes effect after one instruction cycle.
// - bits 15:11 disable timers 5..1; bits 10:8 read zero.
// - bits 7:0 disable i2c1, uart2, uart1, spi2, spi1, can2, can1, adc1.
// - adc1 disabled forces analog pin config off, pins digital.
`timescale 1ns/1ps
`include "psg_consts.vh"

module psg_power_save #(
    parameter [15:0] PRESENT_MASK = 16'hf8ff
) (
    // clock and reset
    input wire CLK_SYS_I,
    input wire SYS_RST_I,
    // wishbone slave
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [7:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    output reg [31:0] WB_DAT_O,
    output reg WB_ACK_O,
    // core request side
    input wire POWER_SAVE_INSTRUCTION_EXEC_I,
    input wire POWER_SAVE_INSTRUCTION_OP_I,
    input wire IRQ_PENDING_I,
    input wire WDT_TIMEOUT_I,
    input wire CLK_SRC_I,
    // peripheral and oscillator side
    output wire CPU_CLK_EN_O,
    output wire PERIPH_CLK_EN_O,
    output reg SYS_OSC_EN_O,
    output reg LOW_POWER_RC_OSCILLATOR_EN_O,
    output reg CLOCK_FAILURE_MONITOR_EN_O,
    output reg WDT_CLEAR_O,
    output reg [15:0] PERIPH_EN_O,
    output reg [15:0] PERIPH_REG_ACCESS_O,
    output reg ANALOG_PIN_CFG_EN_O,
    output reg SLEEP_O,
    output reg IDLE_O,
    output reg CLK_SRC_O
);

// ************************************************************
// state codes
// ************************************************************
localparam [1:0] ST_RUN = 2'd0;
localparam [1:0] ST_SLEEP = 2'd1;
localparam [1:0] ST_IDLE = 2'd2;
localparam [1:0] ST_RESUME = 2'd3;

reg [1:0] state_r;
reg [1:0] state_nxt;
reg [1:0] resume_cnt_r;
reg [1:0] resume_cnt_nxt;
reg [15:0] dis1_r;
reg [15:0] div_r;
reg [15:0] ctl_r;
reg [15:0] dis1_dly_r;
reg [6:0] doze_cnt_r;
reg doze_tick_r;
reg roi_restore_r;
reg wake_irq_s1_r;
reg wake_irq_s2_r;
reg wake_wdt_s1_r;
reg wake_wdt_s2_r;
reg defer_irq_r;
wire wb_req;
wire wake;
wire doze_on;
wire [6:0] doze_lim;

// ************************************************************
// helpers
// ************************************************************
function [15:0] merge16;
    input [15:0] old;
    input [31:0] dat;
    input [3:0] sel;
    input [15:0] msk;
    reg [15:0] v;
    begin
        v = old;
        if (sel[0]) begin
            v[7:0] = dat[7:0];
        end
        if (sel[1]) begin
            v[15:8] = dat[15:8];
        end
        merge16 = v & msk;
    end
endfunction

// ratio code n gives a cpu tick every 2**n system clocks
function [6:0] ratio_limit;
    input [2:0] code;
    begin
        ratio_limit = (7'h01 << code) - 7'h01;
    end
endfunction

// ************************************************************
// wake synchronisers
// ************************************************************
// interrupt and time-out lines may come from blocks that still run while
// the system clock is gated, so treat them as foreign
always @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
        wake_irq_s1_r <= 1'b0;
        wake_irq_s2_r <= 1'b0;
        wake_wdt_s1_r <= 1'b0;
        wake_wdt_s2_r <= 1'b0;
    end else begin
        wake_irq_s1_r <= IRQ_PENDING_I;
        wake_irq_s2_r <= wake_irq_s1_r;
        wake_wdt_s1_r <= WDT_TIMEOUT_I;
        wake_wdt_s2_r <= wake_wdt_s1_r;
    end
end

// reset is handled by SYS_RST_I itself, which returns state to run
assign wake = wake_irq_s2_r | wake_wdt_s2_r | defer_irq_r;

// ************************************************************
// sleep / idle state machine
// ************************************************************
always @* begin
    state_nxt = state_r;
    resume_cnt_nxt = resume_cnt_r;
    case (state_r)
        ST_RUN: begin
            if (POWER_SAVE_INSTRUCTION_EXEC_I) begin
                if (POWER_SAVE_INSTRUCTION_OP_I == `PSG_OP_SLEEP) begin
                    state_nxt = ST_SLEEP;
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
        end
        ST_SLEEP: begin
            if (wake) begin
                state_nxt = ST_RESUME;
                resume_cnt_nxt = 2'd0;
            end
        end
        ST_IDLE: begin
            if (wake) begin
                state_nxt = ST_RESUME;
                resume_cnt_nxt = 2'd0;
            end
        end
        ST_RESUME: begin
            // fixed latency inside the 2 to 4 cycle window
            resume_cnt_nxt = resume_cnt_r + 2'd1;
            if (resume_cnt_r == (`PSG_RESUME_CYC - 1)) begin
                state_nxt = ST_RUN;
            end
        end
        default: begin
            state_nxt = ST_RUN;
        end
    endcase
end

always @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
        state_r <= ST_RUN;
        resume_cnt_r <= 2'd0;
        defer_irq_r <= 1'b0;
        WDT_CLEAR_O <= 1'b0;
        CLK_SRC_O <= 1'b0;
    end else begin
        state_r <= state_nxt;
        resume_cnt_r <= resume_cnt_nxt;
        // interrupt during the instruction is held until entry completes;
        // only the synchronised copy is read, the raw line is foreign
        if (state_r == ST_RUN && POWER_SAVE_INSTRUCTION_EXEC_I && wake_irq_s2_r) begin
            defer_irq_r <= 1'b1;
        end else if (state_r == ST_RESUME) begin
            defer_irq_r <= 1'b0;
        end
        WDT_CLEAR_O <= (state_r == ST_RUN) && POWER_SAVE_INSTRUCTION_EXEC_I;
        if (state_r == ST_RUN && POWER_SAVE_INSTRUCTION_EXEC_I) begin
            CLK_SRC_O <= CLK_SRC_I;
        end
    end
end

// ************************************************************
// oscillator and mode outputs
// ************************************************************
always @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
        SLEEP_O <= 1'b0;
        IDLE_O <= 1'b0;
        SYS_OSC_EN_O <= 1'b1;
        LOW_POWER_RC_OSCILLATOR_EN_O <= 1'b0;
        CLOCK_FAILURE_MONITOR_EN_O <= 1'b0;
    end else begin
        SLEEP_O <= (state_nxt == ST_SLEEP);
        IDLE_O <= (state_nxt == ST_IDLE);
        SYS_OSC_EN_O <= (state_nxt != ST_SLEEP);
        CLOCK_FAILURE_MONITOR_EN_O <= ctl_r[`PSG_CTL_CLOCK_FAILURE_MONITOR_EN_BIT] && (state_nxt != ST_SLEEP);
        if (state_nxt == ST_SLEEP) begin
            LOW_POWER_RC_OSCILLATOR_EN_O <= ctl_r[`PSG_CTL_WDT_EN_BIT];
        end else begin
            LOW_POWER_RC_OSCILLATOR_EN_O <= ctl_r[`PSG_CTL_WDT_EN_BIT] | ctl_r[`PSG_CTL_CLOCK_FAILURE_MONITOR_EN_BIT];
        end
    end
end

// ************************************************************
// doze divider
// ************************************************************
assign doze_on = div_r[`PSG_DIV_CPU_SLOWDOWN_ENABLE_BIT] & ~roi_restore_r;
assign doze_lim = ratio_limit(div_r[`PSG_DIV_RATIO_HI:`PSG_DIV_RATIO_LO]);

always @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
        doze_cnt_r <= 7'h00;
        doze_tick_r <= 1'b1;
        roi_restore_r <= 1'b0;
    end else begin
        if (!doze_on || doze_cnt_r >= doze_lim) begin
            doze_cnt_r <= 7'h00;
            doze_tick_r <= 1'b1;
        end else begin
            doze_cnt_r <= doze_cnt_r + 7'h01;
            doze_tick_r <= 1'b0;
        end
        // full speed until software rewrites the divider register
        if (div_r[`PSG_DIV_ROI_BIT] && wake_irq_s2_r) begin
            roi_restore_r <= 1'b1;
        end else if (wb_req && WB_WE_I && WB_ADR_I == `PSG_ADDR_CLOCK_DIVIDER_REGISTER) begin
            roi_restore_r <= 1'b0;
        end
    end
end

// cpu enable drops in sleep and idle; peripherals only in sleep
assign CPU_CLK_EN_O = (state_r == ST_RUN) & doze_tick_r;
assign PERIPH_CLK_EN_O = (state_r != ST_SLEEP);

// ************************************************************
// peripheral disable outputs
// ************************************************************
always @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
        dis1_dly_r <= `PSG_DIS1_RESET;
        PERIPH_EN_O <= PRESENT_MASK & `PSG_DIS1_MASK;
        PERIPH_REG_ACCESS_O <= PRESENT_MASK & `PSG_DIS1_MASK;
        ANALOG_PIN_CFG_EN_O <= 1'b1;
    end else begin
        // one instruction cycle is two system clocks: register plus stage
        dis1_dly_r <= dis1_r;
        PERIPH_EN_O <= PRESENT_MASK & `PSG_DIS1_MASK & ~dis1_dly_r;
        PERIPH_REG_ACCESS_O <= PRESENT_MASK & `PSG_DIS1_MASK & ~dis1_dly_r;
        ANALOG_PIN_CFG_EN_O <= ~dis1_dly_r[`PSG_ADC1_BIT];
    end
end

// ************************************************************
// wishbone register file
// ************************************************************
assign wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;

always @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
        WB_ACK_O <= 1'b0;
        WB_DAT_O <= 32'h00000000;
        dis1_r <= `PSG_DIS1_RESET;
        div_r <= `PSG_DIV_RESET;
        ctl_r <= `PSG_CTL_RESET;
    end else begin
        WB_ACK_O <= wb_req;
        if (wb_req) begin
            WB_DAT_O <= 32'h00000000;
            case (WB_ADR_I)
                `PSG_ADDR_DISABLE1: begin
                    if (WB_WE_I) begin
                        dis1_r <= merge16(dis1_r, WB_DAT_I, WB_SEL_I, `PSG_DIS1_MASK);
                    end
                    WB_DAT_O <= {16'h0000, dis1_r};
                end
                `PSG_ADDR_CLOCK_DIVIDER_REGISTER: begin
                    if (WB_WE_I) begin
                        div_r <= merge16(div_r, WB_DAT_I, WB_SEL_I, `PSG_DIV_MASK);
                    end
                    WB_DAT_O <= {16'h0000, div_r};
                end
                `PSG_ADDR_CONTROL: begin
                    if (WB_WE_I) begin
                        ctl_r <= merge16(ctl_r, WB_DAT_I, WB_SEL_I, 16'h0003);
                    end
                    WB_DAT_O <= {16'h0000, ctl_r};
                end
                `PSG_ADDR_STATUS: begin
                    WB_DAT_O <= {26'h0000000, roi_restore_r, doze_on, CLK_SRC_O,
                        (state_r == ST_RESUME), IDLE_O, SLEEP_O};
                end
                default: begin
                    WB_DAT_O <= 32'h00000000;
                end
            endcase
        end
    end
end

endmodule

// ==== tb/psg_core_model.sv ====
/* core side model: issues the power save instruction and wake events.
   assumes the bench drives its request lines just after a clock edge. */
`timescale 1ns/1ps
module psg_core_model (
    // requests from the bench
    input wire clk_i,
    input wire go_i,
    input wire op_i,
    input wire irq_i,
    input wire wdt_i,
    // lines to the block
    output reg exec_o = 1'b0,
    output reg op_o = 1'b0,
    output reg irq_o = 1'b0,
    output reg wdt_o = 1'b0
);
    // ****************
    // instruction issue
    // ****************
    always @(posedge clk_i) begin
        exec_o <= go_i;
        // operand only valid with exec, so it toggles otherwise
        op_o <= go_i ? op_i : ~op_o;
        irq_o <= irq_i;
        wdt_o <= wdt_i;
    end
endmodule

// ==== tb/psg_props.sv ====
/* assertions on the power save block ports.
   assumes binding to every psg_power_save instance. */
`timescale 1ns/1ps
module psg_props #(
    parameter [15:0] PRESENT_MASK = 16'hf8ff
) (
    // clock, reset and bus
    input wire CLK_SYS_I,
    input wire SYS_RST_I,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [7:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    input wire WB_ACK_O,
    // core and clock side
    input wire POWER_SAVE_INSTRUCTION_EXEC_I,
    input wire POWER_SAVE_INSTRUCTION_OP_I,
    input wire IRQ_PENDING_I,
    input wire WDT_TIMEOUT_I,
    input wire CLK_SRC_I,
    input wire CPU_CLK_EN_O,
    input wire PERIPH_CLK_EN_O,
    input wire SYS_OSC_EN_O,
    input wire CLOCK_FAILURE_MONITOR_EN_O,
    input wire WDT_CLEAR_O,
    input wire [15:0] PERIPH_EN_O,
    input wire [15:0] PERIPH_REG_ACCESS_O,
    input wire ANALOG_PIN_CFG_EN_O,
    input wire SLEEP_O,
    input wire IDLE_O,
    input wire CLK_SRC_O
);
    // ****************
    // helpers and properties
    // ****************
    wire saving = SLEEP_O || IDLE_O;
    wire run_req = POWER_SAVE_INSTRUCTION_EXEC_I && !saving && CPU_CLK_EN_O;
    wire wr_dis = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_ADR_I == 8'h00
        && WB_SEL_I[1:0] == 2'b11;
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (SYS_RST_I);
    sequence s_resume;
        !CPU_CLK_EN_O ##[1:4] CPU_CLK_EN_O;
    endsequence
    sequence s_dis_apply;
        $stable(PERIPH_EN_O) ##1 $stable(PERIPH_EN_O)
            ##1 PERIPH_EN_O == (~$past(WB_DAT_I[15:0], 3) & PRESENT_MASK);
    endsequence
    a_ack_one_pulse: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O)
        else $error("ack not a single cycle answer");
    a_entry_mode: assert property
        (run_req |=> saving && WDT_CLEAR_O && IDLE_O == $past(POWER_SAVE_INSTRUCTION_OP_I))
        else $error("power save entry wrong");
    a_save_cpu_off: assert property (saving |-> !CPU_CLK_EN_O)
        else $error("cpu clock runs while saving");
    a_sleep_clocks_off: assert property
        (SLEEP_O |-> !SYS_OSC_EN_O && !PERIPH_CLK_EN_O && !CLOCK_FAILURE_MONITOR_EN_O)
        else $error("clock left on in sleep");
    a_idle_periph_on: assert property (IDLE_O |-> PERIPH_CLK_EN_O && SYS_OSC_EN_O)
        else $error("peripheral clock off in idle");
    a_wake_bound: assert property
        (saving && (IRQ_PENDING_I || WDT_TIMEOUT_I) |-> ##[1:5] !saving)
        else $error("no wake on event");
    a_resume_delay: assert property ($fell(IDLE_O) |-> s_resume)
        else $error("cpu resume delay wrong");
    a_src_latched: assert property
        ($rose(SLEEP_O) |-> CLK_SRC_O == $past(CLK_SRC_I) ##1 $stable(CLK_SRC_O))
        else $error("clock source not kept");
    a_dis_delay: assert property (wr_dis |=> s_dis_apply)
        else $error("disable write applied at wrong time");
    a_access_match: assert property (PERIPH_REG_ACCESS_O == PERIPH_EN_O)
        else $error("register access differs from enable");
    a_adc_digital: assert property
        ($stable(PERIPH_EN_O[0]) |-> ANALOG_PIN_CFG_EN_O == PERIPH_EN_O[0])
        else $error("analog pins not digital");
endmodule
bind psg_power_save psg_props #(.PRESENT_MASK(PRESENT_MASK)) psg_props_i (.*);

// ==== tb/tb_top.sv ====
/* self-checking bench for the power save block.
   assumes the block answers wishbone and the core model feeds it. */
`timescale 1ns/1ps
`include "psg_consts.vh"
module tb_top;
    logic CLK_SYS_I, SYS_RST_I, WB_CYC_I, WB_STB_I, WB_WE_I, CLK_SRC_I;
    logic [7:0] WB_ADR_I;
    logic [3:0] WB_SEL_I;
    logic [31:0] WB_DAT_I;
    wire [31:0] WB_DAT_O;
    wire WB_ACK_O, POWER_SAVE_INSTRUCTION_EXEC_I, POWER_SAVE_INSTRUCTION_OP_I, IRQ_PENDING_I, WDT_TIMEOUT_I;
    wire CPU_CLK_EN_O, PERIPH_CLK_EN_O, SYS_OSC_EN_O, LOW_POWER_RC_OSCILLATOR_EN_O, CLOCK_FAILURE_MONITOR_EN_O, WDT_CLEAR_O;
    wire ANALOG_PIN_CFG_EN_O, SLEEP_O, IDLE_O, CLK_SRC_O;
    wire [15:0] PERIPH_EN_O, PERIPH_REG_ACCESS_O;
    logic go, op, irq, wdt;
    logic [15:0] q;
    int err_total, comparisons, cycles, k, t;
    psg_power_save psg_power_save_i (.*);
    psg_core_model psg_core_model_i (.clk_i(CLK_SYS_I), .go_i(go), .op_i(op), .irq_i(irq),
        .wdt_i(wdt), .exec_o(POWER_SAVE_INSTRUCTION_EXEC_I), .op_o(POWER_SAVE_INSTRUCTION_OP_I), .irq_o(IRQ_PENDING_I),
        .wdt_o(WDT_TIMEOUT_I));
    // ****************
    // tasks
    // ****************
    task check(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge CLK_SYS_I);
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I <= w;
        WB_ADR_I <= a;
        WB_DAT_I <= {16'h0000, d};
        do @(posedge CLK_SYS_I); while (WB_ACK_O !== 1'b1);
        q = WB_DAT_O[15:0];
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
    endtask
    // settle first: the divider may finish an old period after a change
    task ticks(input int e);
        k = 0;
        t = 0;
        repeat (128) @(posedge CLK_SYS_I);
        repeat (256) begin
            @(posedge CLK_SYS_I);
            k += (CPU_CLK_EN_O === 1'b1);
            t += (PERIPH_CLK_EN_O === 1'b1);
        end
        check("cpu", k, e);
        check("per", t, 256);
    endtask
    task enter(input logic o, input logic w);
        @(posedge CLK_SYS_I);
        go <= 1'b1;
        op <= o;
        if (w) irq <= 1'b1;
        @(posedge CLK_SYS_I);
        go <= 1'b0;
        while (SLEEP_O !== 1'b1 && IDLE_O !== 1'b1) @(posedge CLK_SYS_I);
    endtask
    task leave;
        while (SLEEP_O !== 1'b0 || IDLE_O !== 1'b0) @(posedge CLK_SYS_I);
        k = 0;
        while (CPU_CLK_EN_O !== 1'b1) begin
            k++;
            @(posedge CLK_SYS_I);
        end
    endtask
    task test_done;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ****************
    // clock, timeout and sequence
    // ****************
    initial begin
        CLK_SYS_I = 1'b0;
        forever #10 CLK_SYS_I = ~CLK_SYS_I;
    end
    always @(posedge CLK_SYS_I) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            test_done();
        end
    end
    initial begin
        SYS_RST_I = 1'b1;
        {WB_CYC_I, WB_STB_I, WB_WE_I, go, op, irq, wdt, CLK_SRC_I} = 8'h00;
        WB_ADR_I = 8'h00;
        WB_DAT_I = 32'h00000000;
        WB_SEL_I = 4'h3;
        repeat (10) @(posedge CLK_SYS_I);
        SYS_RST_I <= 1'b0;
        @(posedge CLK_SYS_I);
        check("en", PERIPH_EN_O, 16'hf8ff);
        wb(0, `PSG_ADDR_DISABLE1, 16'h0000);
        check("dis", q, 16'h0000);
        wb(0, 8'h10, 16'h0000);
        check("unm", q, 16'h0000);
        wb(1, `PSG_ADDR_DISABLE1, 16'hffff);
        wb(0, `PSG_ADDR_DISABLE1, 16'h0000);
        check("dis", q, 16'hf8ff);
        for (int i = 0; i < 16; i++) begin
            wb(1, `PSG_ADDR_DISABLE1, 16'h0001 << i);
            repeat (3) @(posedge CLK_SYS_I);
            check("en", PERIPH_EN_O, 16'hf8ff & ~(16'h0001 << i));
            check("ana", ANALOG_PIN_CFG_EN_O, i != 0);
        end
        wb(1, `PSG_ADDR_DISABLE1, 16'h0000);
        for (int n = 0; n < 8; n++) begin
            wb(1, `PSG_ADDR_CLOCK_DIVIDER_REGISTER, 16'(32'h0800 | (n << 12)));
            ticks(256 >> n);
        end
        wb(1, `PSG_ADDR_CLOCK_DIVIDER_REGISTER, 16'h3000);
        ticks(256);
        for (int r = 0; r < 2; r++) begin
            wb(1, `PSG_ADDR_CLOCK_DIVIDER_REGISTER, r ? 16'ha800 : 16'h2800);
            irq <= 1'b1;
            repeat (6) @(posedge CLK_SYS_I);
            irq <= 1'b0;
            ticks(r ? 256 : 64);
        end
        wb(1, `PSG_ADDR_CLOCK_DIVIDER_REGISTER, 16'h0000);
        wb(1, `PSG_ADDR_CONTROL, 16'h0001);
        CLK_SRC_I <= 1'b1;
        enter(`PSG_OP_SLEEP, 1'b0);
        CLK_SRC_I <= 1'b0;
        check("low_power_rc_oscillator", LOW_POWER_RC_OSCILLATOR_EN_O, 1);
        check("osc", {SYS_OSC_EN_O, CLOCK_FAILURE_MONITOR_EN_O, PERIPH_CLK_EN_O}, 0);
        wdt <= 1'b1;
        leave;
        wdt <= 1'b0;
        check("src", CLK_SRC_O, 1);
        wb(1, `PSG_ADDR_CONTROL, 16'h0002);
        enter(`PSG_OP_IDLE, 1'b0);
        check("low_power_rc_oscillator", LOW_POWER_RC_OSCILLATOR_EN_O, 1);
        check("clk", {SYS_OSC_EN_O, PERIPH_CLK_EN_O}, 2'b11);
        irq <= 1'b1;
        leave;
        check("res", k >= 1 && k <= 4, 1);
        irq <= 1'b0;
        repeat (4) @(posedge CLK_SYS_I);
        enter(`PSG_OP_IDLE, 1'b1);
        leave;
        irq <= 1'b0;
        check("idle", IDLE_O, 0);
        enter(`PSG_OP_SLEEP, 1'b0);
        SYS_RST_I <= 1'b1;
        repeat (2) @(posedge CLK_SYS_I);
        SYS_RST_I <= 1'b0;
        @(posedge CLK_SYS_I);
        check("rst", {SLEEP_O, SYS_OSC_EN_O, PERIPH_CLK_EN_O}, 3'b011);
        test_done();
    end
endmodule
